//--- hw/stm_pkg.sv
// Register map, field positions, reset values and encodings of the standard timer.
package stm_pkg;
  localparam logic [11:0] STM_OFS_CTRL_A   = 12'h000;
  localparam logic [11:0] STM_OFS_CTRL_B   = 12'h004;
  localparam logic [11:0] STM_OFS_CNT_LO   = 12'h008;
  localparam logic [11:0] STM_OFS_CNT_HI   = 12'h00C;
  localparam logic [11:0] STM_OFS_CMPA_LO  = 12'h010;
  localparam logic [11:0] STM_OFS_CMPA_HI  = 12'h014;
  localparam logic [11:0] STM_OFS_PERIOD   = 12'h018;
  localparam logic [11:0] STM_OFS_STATUS   = 12'h01C;
  localparam logic [7:0]  STM_RST_BYTE     = 8'h00;
  localparam logic [7:0]  STM_CTRL_A_MASK  = 8'hF8;
  // Control A fields.
  localparam int STM_A_PAUSE_BIT = 7;
  localparam int STM_A_CLK_MSB   = 6;
  localparam int STM_A_CLK_LSB   = 4;
  localparam int STM_A_ON_BIT    = 3;
  // Control B fields.
  localparam int STM_B_MODE_MSB  = 7;
  localparam int STM_B_MODE_LSB  = 6;
  localparam int STM_B_FUNC_MSB  = 5;
  localparam int STM_B_FUNC_LSB  = 4;
  localparam int STM_B_OC_BIT    = 3;
  localparam int STM_B_POL_BIT   = 2;
  localparam int STM_B_DPX_BIT   = 1;
  localparam int STM_B_CCLR_BIT  = 0;
  // Status fields.
  localparam int STM_S_AF_BIT    = 0;
  localparam int STM_S_PF_BIT    = 1;
  localparam int STM_S_OUT_BIT   = 2;
  localparam int STM_S_CAP_BIT   = 3;
  // Prescale counts.
  localparam int STM_DIV_SYS4    = 4;
  localparam int STM_DIV_H16     = 16;
  localparam int STM_DIV_H64     = 64;
  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'b00,
    STM_MODE_CAP = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TMR = 2'b11
  } stm_mode_t;
  typedef enum logic [2:0] {
    STM_CK_SYS4  = 3'b000,
    STM_CK_SYS   = 3'b001,
    STM_CK_H16   = 3'b010,
    STM_CK_H64   = 3'b011,
    STM_CK_TBC0  = 3'b100,
    STM_CK_TBC1  = 3'b101,
    STM_CK_EXTR  = 3'b110,
    STM_CK_EXTF  = 3'b111
  } stm_clk_t;
endpackage : stm_pkg

//--- hw/stm_tick_if.sv
// Counter tick and its source selection between the top and the prescaler.
interface stm_tick_if;
  import stm_pkg::*;
  logic [2:0] clock_select;
  logic       tick;
  modport src (input clock_select, output tick);
  modport dst (output clock_select, input tick);
endinterface : stm_tick_if

//--- hw/stm_prescaler.sv
// Counter tick generation: internal dividers and synchronised external clock edges.
module stm_prescaler (
  input  wire logic pclk,            // System clock.
  input  wire logic presetn,         // Asynchronous reset, active low.
  input  wire logic high_clock_en,   // High clock enable pulse, same domain.
  input  wire logic timebase_clock,  // Timebase clock pin, asynchronous.
  input  wire logic external_clock_pin, // External clock pin, asynchronous.
  stm_tick_if.src   tk               // Selection in, tick out.
);
  import stm_pkg::*;

  logic [1:0] sys_div_reg;
  logic [5:0] h_div_reg;
  logic [1:0] ext_sync_reg;
  logic       ext_last_reg;
  logic [1:0] tbc_sync_reg;
  logic       tbc_last_reg;
  logic       tick_reg;

  wire ext_rise = ext_sync_reg[1] & ~ext_last_reg;
  wire ext_fall = ~ext_sync_reg[1] & ext_last_reg;
  wire tbc_rise = tbc_sync_reg[1] & ~tbc_last_reg;
  wire sys4_hit = (sys_div_reg == 2'(STM_DIV_SYS4 - 1));
  wire h16_hit  = high_clock_en & (h_div_reg[3:0] == 4'(STM_DIV_H16 - 1));
  wire h64_hit  = high_clock_en & (h_div_reg == 6'(STM_DIV_H64 - 1));
  logic tick_next;

  always_comb begin
    case (stm_clk_t'(tk.clock_select))
      STM_CK_SYS4: tick_next = sys4_hit;
      STM_CK_SYS:  tick_next = 1'b1;
      STM_CK_H16:  tick_next = h16_hit;
      STM_CK_H64:  tick_next = h64_hit;
      STM_CK_TBC0: tick_next = tbc_rise;
      STM_CK_TBC1: tick_next = tbc_rise;
      STM_CK_EXTR: tick_next = ext_rise;
      STM_CK_EXTF: tick_next = ext_fall;
      default:     tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div_reg  <= 2'h0;
      h_div_reg    <= 6'h00;
      ext_sync_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      tbc_sync_reg <= 2'h0;
      tbc_last_reg <= 1'b0;
      tick_reg     <= 1'b0;
    end else begin
      sys_div_reg  <= sys_div_reg + 2'h1;
      if (high_clock_en) begin
        h_div_reg <= h_div_reg + 6'h01;
      end
      ext_sync_reg <= {ext_sync_reg[0], external_clock_pin};
      ext_last_reg <= ext_sync_reg[1];
      tbc_sync_reg <= {tbc_sync_reg[0], timebase_clock};
      tbc_last_reg <= tbc_sync_reg[1];
      tick_reg     <= tick_next;
    end
  end

  assign tk.tick = tick_reg;
endmodule : stm_prescaler

//--- hw/stm_capture.sv
// Capture-input pin synchroniser and edge trigger.
module stm_capture (
  input  wire logic       pclk,              // System clock.
  input  wire logic       presetn,           // Asynchronous reset, active low.
  input  wire logic       capture_input_pin, // Capture pin, asynchronous.
  input  wire logic [1:0] edge_sel,          // Trigger edge selection.
  output logic            capture_hit        // One-cycle capture trigger.
);
  import stm_pkg::*;

  logic [1:0] sync_reg;
  logic       last_reg;

  wire rise = sync_reg[1] & ~last_reg;
  wire fall = ~sync_reg[1] & last_reg;

  // Capture trigger edge: rising, falling, both or disabled.
  assign capture_hit = (edge_sel == 2'b00) ? rise :
                       (edge_sel == 2'b01) ? fall :
                       (edge_sel == 2'b10) ? (rise | fall) : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= 2'h0;
      last_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], capture_input_pin};
      last_reg <= sync_reg[1];
    end
  end
endmodule : stm_capture

//--- hw/stm_timer.sv
// Standard timer top: APB registers, 16-bit counter, comparators and output pin.
//
// Our own choices: the register addresses and the APB interface to the registers.
module stm_timer (
  input  wire logic        pclk,               // System clock, 25 MHz.
  input  wire logic        presetn,            // Asynchronous reset, active low.
  input  wire logic        psel,               // APB select.
  input  wire logic        penable,            // APB enable.
  input  wire logic        pwrite,             // APB write.
  input  wire logic [11:0] paddr,              // APB byte address.
  input  wire logic [31:0] pwdata,             // APB write data.
  input  wire logic [3:0]  pstrb,              // APB byte strobes.
  output logic             pready,             // APB ready.
  output logic [31:0]      prdata,             // APB read data.
  output logic             pslverr,            // APB error on unmapped address.
  input  wire logic        high_clock_en,      // High clock enable pulse.
  input  wire logic        timebase_clock,     // Timebase clock, asynchronous.
  input  wire logic        external_clock_pin, // External count clock pin.
  input  wire logic        capture_input_pin,  // Capture input pin.
  output logic             timer_out,          // Timer output pin level.
  output logic             timer_out_en_n,     // Output pin enable, active low.
  output logic             timer_irq           // Interrupt request pulse.
);
  import stm_pkg::*;

  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [15:0] cmpa_reg;
  logic [7:0]  period_reg;
  logic [15:0] count_reg;
  logic [15:0] capt_reg;
  logic        on_last_reg;
  logic        out_reg;
  logic        pwm_reg;
  logic        pulse_reg;
  logic        af_reg;
  logic        pf_reg;
  logic        cap_flag_reg;
  logic        pin_reg;
  logic        pin_en_n_reg;
  logic        irq_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        capture_hit;

  stm_tick_if tk ();

  stm_prescaler u_pre (
    .pclk               (pclk),
    .presetn            (presetn),
    .high_clock_en      (high_clock_en),
    .timebase_clock     (timebase_clock),
    .external_clock_pin (external_clock_pin),
    .tk                 (tk)
  );

  // Fields.
  wire        counter_pause         = ctrl_a_reg[STM_A_PAUSE_BIT];
  wire        module_on             = ctrl_a_reg[STM_A_ON_BIT];
  wire [1:0]  operating_mode_field  = ctrl_b_reg[STM_B_MODE_MSB:STM_B_MODE_LSB];
  wire [1:0]  output_function_field = ctrl_b_reg[STM_B_FUNC_MSB:STM_B_FUNC_LSB];
  wire        output_control        = ctrl_b_reg[STM_B_OC_BIT];
  wire        output_polarity       = ctrl_b_reg[STM_B_POL_BIT];
  wire        period_duty_select    = ctrl_b_reg[STM_B_DPX_BIT];
  wire        clear_select          = ctrl_b_reg[STM_B_CCLR_BIT];
  assign tk.clock_select = ctrl_a_reg[STM_A_CLK_MSB:STM_A_CLK_LSB];

  stm_capture u_cap (
    .pclk              (pclk),
    .presetn           (presetn),
    .capture_input_pin (capture_input_pin),
    .edge_sel          (output_function_field),
    .capture_hit       (capture_hit)
  );

  wire mode_cmp = (operating_mode_field == STM_MODE_CMP);
  wire mode_cap = (operating_mode_field == STM_MODE_CAP);
  wire mode_pwm = (operating_mode_field == STM_MODE_PWM);
  wire mode_tmr = (operating_mode_field == STM_MODE_TMR);
  wire single   = mode_pwm & (output_function_field == 2'b11);

  // Counting happens only while on, not paused, on a selected tick.
  wire on_rise = module_on & ~on_last_reg;
  wire run     = module_on & ~counter_pause & tk.tick;
  wire [15:0] count_inc = count_reg + 16'h0001;

  // Matches are judged on the value the counter is about to take.
  wire match_a  = run & (count_inc == cmpa_reg);
  wire p_zero   = (period_reg == 8'h00);
  wire match_p  = run & (p_zero ? (count_reg == 16'hFFFF) : (count_inc[15:8] == period_reg) &
                  (count_inc[7:0] == 8'h00));
  wire clr_by_a = mode_pwm ? period_duty_select : ((mode_cmp | mode_tmr) & clear_select);
  wire clr_by_p = mode_pwm ? ~period_duty_select : ((mode_cmp | mode_tmr) & ~clear_select);
  wire auto_clr = (clr_by_a & match_a) | (clr_by_p & match_p);
  wire set_af   = match_a & ~mode_cap;
  wire set_pf   = match_p & ~mode_cap & ~((mode_cmp | mode_tmr) & clear_select);

  // PWM level: active while the counter sits below the duty value.
  wire [16:0] duty_val  = period_duty_select ? (p_zero ? 17'h10000 : {1'b0, period_reg, 8'h00})
                                             : {1'b0, cmpa_reg};
  wire        pwm_act   = ({1'b0, count_reg} < duty_val);

  // Compare-mode requested level on an A match.
  logic out_next;
  always_comb begin
    case (output_function_field)
      2'b01:   out_next = 1'b0;
      2'b10:   out_next = 1'b1;
      2'b11:   out_next = ~out_reg;
      default: out_next = out_reg;
    endcase
  end

  // Pin level before polarity.
  logic pin_raw;
  always_comb begin
    if (mode_pwm) begin
      case (output_function_field)
        2'b00:   pin_raw = ~output_control;
        2'b01:   pin_raw = output_control;
        2'b10:   pin_raw = pwm_act ~^ output_control;
        default: pin_raw = pulse_reg ? output_control : ~output_control;
      endcase
    end else begin
      pin_raw = out_reg;
    end
  end

  // APB decode.
  wire        apb_setup = psel & ~penable;
  wire        apb_wr    = psel & penable & pready_reg & pwrite & pstrb[0];
  wire        hit_a     = (paddr == STM_OFS_CTRL_A);
  wire        hit_b     = (paddr == STM_OFS_CTRL_B);
  wire        hit_al    = (paddr == STM_OFS_CMPA_LO);
  wire        hit_ah    = (paddr == STM_OFS_CMPA_HI);
  wire        hit_p     = (paddr == STM_OFS_PERIOD);
  wire        hit_st    = (paddr == STM_OFS_STATUS);
  wire        mapped    = hit_a | hit_b | hit_al | hit_ah | hit_p | hit_st |
                          (paddr == STM_OFS_CNT_LO) | (paddr == STM_OFS_CNT_HI);
  wire        st_clr    = apb_wr & hit_st;
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      STM_OFS_CTRL_A:  rd_byte = ctrl_a_reg & STM_CTRL_A_MASK;
      STM_OFS_CTRL_B:  rd_byte = ctrl_b_reg;
      STM_OFS_CNT_LO:  rd_byte = mode_cap ? capt_reg[7:0] : count_reg[7:0];
      STM_OFS_CNT_HI:  rd_byte = mode_cap ? capt_reg[15:8] : count_reg[15:8];
      STM_OFS_CMPA_LO: rd_byte = cmpa_reg[7:0];
      STM_OFS_CMPA_HI: rd_byte = cmpa_reg[15:8];
      STM_OFS_PERIOD:  rd_byte = period_reg;
      STM_OFS_STATUS:  rd_byte = {4'h0, cap_flag_reg, out_reg, pf_reg, af_reg};
      default:         rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg  <= STM_RST_BYTE;
      ctrl_b_reg  <= STM_RST_BYTE;
      cmpa_reg    <= {STM_RST_BYTE, STM_RST_BYTE};
      period_reg  <= STM_RST_BYTE;
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~mapped;
      prdata_reg  <= (apb_setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // Counter bytes are not writable.
      if (apb_wr && hit_a) begin
        ctrl_a_reg <= pwdata[7:0] & STM_CTRL_A_MASK;
      end
      if (apb_wr && hit_b) begin
        ctrl_b_reg <= pwdata[7:0];
      end
      if (apb_wr && hit_al) begin
        cmpa_reg[7:0] <= pwdata[7:0];
      end
      if (apb_wr && hit_ah) begin
        cmpa_reg[15:8] <= pwdata[7:0];
      end
      if (apb_wr && hit_p) begin
        period_reg <= pwdata[7:0];
      end
      // Single-pulse trailing edge switches the module off.
      if (module_on && single && match_a) begin
        ctrl_a_reg[STM_A_ON_BIT] <= 1'b0;
      end
    end
  end

  // Counter, output state and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg    <= 16'h0000;
      capt_reg     <= 16'h0000;
      on_last_reg  <= 1'b0;
      out_reg      <= 1'b0;
      pulse_reg    <= 1'b0;
      af_reg       <= 1'b0;
      pf_reg       <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else begin
      on_last_reg <= module_on;
      if (on_rise) begin
        count_reg <= 16'h0000;
      end else if (run) begin
        count_reg <= auto_clr ? 16'h0000 : count_inc;
      end
      if (on_rise && mode_cmp) begin
        out_reg <= output_control;
      end else if (match_a && mode_cmp) begin
        out_reg <= out_next;
      end
      pulse_reg <= module_on & single;
      if (module_on && mode_cap && capture_hit) begin
        capt_reg <= count_reg;
      end
      // A new event wins over a software clear in the same cycle.
      af_reg       <= set_af | (af_reg & ~(st_clr & pwdata[STM_S_AF_BIT]));
      pf_reg       <= set_pf | (pf_reg & ~(st_clr & pwdata[STM_S_PF_BIT]));
      cap_flag_reg <= (module_on & mode_cap & capture_hit) |
                      (cap_flag_reg & ~(st_clr & pwdata[STM_S_CAP_BIT]));
    end
  end

  // Registered pin drive; the pin is released in timer/counter and capture modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg      <= 1'b0;
      pin_en_n_reg <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      pin_reg      <= pin_raw ^ output_polarity;
      pin_en_n_reg <= mode_tmr | mode_cap;
      irq_reg      <= set_af | set_pf | (module_on & mode_cap & capture_hit);
    end
  end

  assign pready         = pready_reg;
  assign prdata         = prdata_reg;
  assign pslverr        = pslverr_reg;
  assign timer_out      = pin_reg;
  assign timer_out_en_n = pin_en_n_reg;
  assign timer_irq      = irq_reg;
endmodule : stm_timer

//--- dv/stm_timer_props.sv
// Port-level checks of the standard timer, attached to its top module by bind.
module stm_timer_props
  import stm_pkg::*;
(
  input wire logic        pclk,           // Clock.
  input wire logic        presetn,        // Reset.
  input wire logic        psel,           // APB.
  input wire logic        penable,        // APB.
  input wire logic        pwrite,         // APB.
  input wire logic [11:0] paddr,          // APB.
  input wire logic [31:0] pwdata,         // APB.
  input wire logic [3:0]  pstrb,          // APB.
  input wire logic        pready,         // APB.
  input wire logic [31:0] prdata,         // APB.
  input wire logic        pslverr,        // APB.
  input wire logic        timer_out,      // Pin level.
  input wire logic        timer_out_en_n, // Pin enable.
  input wire logic        timer_irq       // Interrupt.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] ctl_a_m;
  logic [7:0] ctl_b_m;
  logic [1:0] quiet_cnt;
  wire        wr_fire = psel && penable && pready && pwrite && pstrb[0];
  wire        quiet   = (!ctl_a_m[STM_A_ON_BIT] || ctl_a_m[STM_A_PAUSE_BIT]) && ctl_b_m[7:6] != STM_MODE_CAP;
  // Control mirrors let pin and interrupt rules be judged from the bus alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_a_m   <= 8'h00;
      ctl_b_m   <= 8'h00;
      quiet_cnt <= 2'h0;
    end else begin
      if (wr_fire && paddr == STM_OFS_CTRL_A) ctl_a_m <= pwdata[7:0] & STM_CTRL_A_MASK;
      if (wr_fire && paddr == STM_OFS_CTRL_B) ctl_b_m <= pwdata[7:0];
      quiet_cnt <= !quiet ? 2'h0 : quiet_cnt + {1'b0, quiet_cnt != 2'h3};
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("No answer after setup.");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("Ready outside an access.");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("Refused read returned data.");
  ctrl_a_read_a: assert property (pready && !pwrite && !pslverr && paddr == STM_OFS_CTRL_A && ctl_b_m[7:4] != 4'hB
    |-> prdata == {24'h000000, ctl_a_m}) else $error("Control A read wrong.");
  pin_enable_a: assert property ($past(presetn) && $stable(ctl_b_m[7:6])
    |-> timer_out_en_n == (ctl_b_m[7:6] inside {STM_MODE_TMR, STM_MODE_CAP})) else $error("Pin enable wrong.");
  quiet_irq_a: assert property (quiet_cnt == 2'h3 |-> !timer_irq)
    else $error("Interrupt while stopped.");
  on_init_a: assert property (ctl_a_m[STM_A_ON_BIT] && !$past(ctl_a_m[STM_A_ON_BIT]) && ctl_b_m[7:6] == STM_MODE_CMP
    |-> ##[1:2] timer_out == (ctl_b_m[3] ^ ctl_b_m[2])) else $error("Pin not at initial level.");
  // The interrupt pulse leads the pin by one cycle, and a control write moves the pin up to two cycles later.
  pin_on_match_a: assert property (ctl_b_m[7:6] == STM_MODE_CMP && ctl_a_m == $past(ctl_a_m, 3)
    && ctl_b_m == $past(ctl_b_m, 3) && timer_out != $past(timer_out) |-> $past(timer_irq))
    else $error("Compare pin moved without a match.");
  irq_seen_c: cover property (timer_irq);
  err_seen_c: cover property (pready && pslverr);
  pause_hold_c: cover property (quiet_cnt == 2'h3 && ctl_a_m[STM_A_ON_BIT]);
endmodule : stm_timer_props

bind stm_timer stm_timer_props i_stm_timer_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .prdata, .pslverr, .timer_out, .timer_out_en_n, .timer_irq);

//--- dv/stm_timer_tb.sv
// Self-checking bench for the standard timer with a register model and timing expectations.
module stm_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stm_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic        high_clock_en = 1'b0;
  logic        timebase_clock = 1'b0;
  logic        external_clock_pin = 1'b0;
  logic        capture_input_pin = 1'b0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        timer_out;
  logic        timer_out_en_n;
  logic        timer_irq;
  logic [7:0]  model [8];
  logic [31:0] r;
  logic [7:0]  b;
  logic        e;
  int          err_count = 0;
  int          checked = 0;
  int          seed = 92403;
  int          tb_div = 0;
  int          n;
  int          fac [6] = '{4, 1, 32, 128, 6, 6};
  stm_timer i_stm_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .high_clock_en, .timebase_clock, .external_clock_pin, .capture_input_pin, .timer_out,
    .timer_out_en_n, .timer_irq);
  always #20 pclk = ~pclk;
  // Enable every second cycle and a rising timebase edge every sixth keep divided rates exact multiples.
  always @(posedge pclk) begin
    high_clock_en <= ~high_clock_en;
    tb_div        <= (tb_div == 2) ? 0 : tb_div + 1;
    if (tb_div == 2) timebase_clock <= ~timebase_clock;
  end
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] wmask(input logic [11:0] a);
    case (a)
      STM_OFS_CTRL_A: return STM_CTRL_A_MASK;
      STM_OFS_CNT_LO, STM_OFS_CNT_HI, STM_OFS_STATUS: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : wmask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] rv, output logic ev);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w && a < 12'h020) model[a[4:2]] = d & wmask(a);
    if (k >= 20) begin
      err_count++;
      print_verdict();
    end
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rv;
    logic        ev;
    xfer(a, 1'b1, d, rv, ev);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] rv);
    logic ev;
    xfer(a, 1'b0, 8'h00, rv, ev);
  endtask : rd
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (timer_irq !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_irq
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge pclk);
      external_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      external_clock_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulse
  task automatic start(input logic [7:0] cb, input logic [15:0] ca, input logic [7:0] p, input logic [7:0] ca0);
    wr(STM_OFS_CTRL_A, 8'h00);
    wr(STM_OFS_CTRL_B, cb);
    wr(STM_OFS_CMPA_LO, ca[7:0]);
    wr(STM_OFS_CMPA_HI, ca[15:8]);
    wr(STM_OFS_PERIOD, p);
    wr(STM_OFS_STATUS, 8'h0F);
    wr(STM_OFS_CTRL_A, ca0);
  endtask : start
  initial begin
    foreach (model[i]) model[i] = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4), r);
      chk(r, 32'h0000_0000);
    end
    xfer(12'h020, 1'b0, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0000_0000);
    for (int i = 2; i < 9; i++) begin
      b = 8'($random(seed));
      // The on bit stays low so later mode writes happen with the timer off.
      if (i == 7) b[STM_A_ON_BIT] = 1'b0;
      wr(12'((i % 7) * 4), b);
      rd(12'((i % 7) * 4), r);
      chk(r, {24'h0, model[i % 7]});
    end
    for (int s = 0; s < 6; s++) begin
      start(8'hC1, 16'h000A, 8'h00, {1'b0, 3'(s), 4'h8});
      wait_irq(n);
      wait_irq(n);
      chk(n, 10 * fac[s]);
      chk({31'h0, timer_out_en_n}, 32'h1);
    end
    rd(STM_OFS_STATUS, r);
    chk({30'h0, r[1:0]}, 32'h1);
    for (int p = 1; p < 4; p += 2) begin
      start(8'hC0, 16'hFFFF, 8'(p), 8'h18);
      wait_irq(n);
      wait_irq(n);
      chk(n, 256 * p);
    end
    rd(STM_OFS_STATUS, r);
    chk({30'h0, r[1:0]}, 32'h2);
    for (int s = 6; s < 8; s++) begin
      start(8'hC1, 16'h03E8, 8'h00, {1'b1, 3'(s), 4'h8});
      pulse(3);
      rd(STM_OFS_CNT_LO, r);
      chk(r, 32'h0);
      wr(STM_OFS_CTRL_A, {1'b0, 3'(s), 4'h8});
      pulse(3);
      repeat (4) @(posedge pclk);
      rd(STM_OFS_CNT_LO, r);
      chk(r, 32'h3);
      wr(STM_OFS_CNT_LO, 8'h55);
      wr(STM_OFS_CTRL_A, {1'b0, 3'(s), 4'h0});
      pulse(2);
      rd(STM_OFS_CNT_LO, r);
      chk(r, 32'h3);
      wr(STM_OFS_CTRL_A, {1'b0, 3'(s), 4'h8});
      rd(STM_OFS_CNT_LO, r);
      chk(r, 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      b = {2'b00, 2'(k >> 1), k[0], 1'($random(seed)), 2'b01};
      start(b, 16'h0028, 8'h00, 8'h18);
      repeat (3) @(posedge pclk);
      chk({31'h0, timer_out}, {31'h0, b[3] ^ b[2]});
      wait_irq(n);
      repeat (2) @(posedge pclk);
      chk({31'h0, timer_out}, {31'h0, (b[5:4] == 2'b00 ? b[3] : b[5:4] == 2'b11 ? !b[3] : b[5]) ^ b[2]});
    end
    for (int k = 0; k < 4; k++) begin
      b = {3'b100, k[1], k[0], 1'($random(seed)), 2'b00};
      start(b, 16'h0040, 8'h01, 8'h18);
      repeat (4) @(posedge pclk);
      chk({31'h0, timer_out}, {31'h0, (b[4] ? b[3] : !b[3]) ^ b[2]});
    end
    for (int d = 0; d < 2; d++) begin
      start(8'hA8 | 8'(d * 2), d ? 16'h0200 : 16'h0040, 8'h01, 8'h18);
      repeat (600) @(posedge pclk);
      n = 0;
      repeat (256 << d) begin
        @(posedge pclk);
        n += (timer_out === 1'b1);
      end
      chk(n, d ? 256 : 64);
    end
    for (int f = 0; f < 4; f++) begin
      start({2'b01, 2'(f), 4'h0}, 16'hFFFF, 8'h00, 8'h18);
      for (int v = 1; v >= 0; v--) begin
        capture_input_pin <= 1'(v);
        repeat (6) @(posedge pclk);
        rd(STM_OFS_STATUS, r);
        chk({31'h0, r[3]}, {31'h0, f == 2 || f == (1 - v)});
        wr(STM_OFS_STATUS, 8'h08);
      end
    end
    print_verdict();
  end
endmodule : stm_timer_tb
